// File: pkg/lcp_pkg.sv
// constants, register map and state layout of the led channel control block
// assumes a byte-wide register port fed by a serial slave outside this block
package lcp_pkg;

	// ************************************************************
	// sizes
	// ************************************************************
	localparam int NCH = 30;
	localparam int GROUP_SIZE = 10;
	localparam int CLK_MHZ = 100;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_UPDATE = 8'h49;
	localparam logic [7:0] ADDR_GLOBAL = 8'h6e;
	localparam logic [7:0] ADDR_PHASE = 8'h70;
	localparam logic [7:0] ADDR_DETECT = 8'h71;
	localparam logic [7:0] ADDR_FAULT0 = 8'h72;
	localparam logic [7:0] ADDR_FAULT1 = 8'h73;
	localparam logic [7:0] ADDR_FAULT2 = 8'h74;
	localparam logic [7:0] ADDR_FAULT3 = 8'h75;
	localparam logic [7:0] ADDR_FAULT4 = 8'h76;
	localparam logic [7:0] ADDR_THERMAL = 8'h77;
	localparam logic [7:0] ADDR_SPREAD = 8'h78;
	localparam logic [7:0] ADDR_RESET = 8'h7f;
	// duty low byte and scale bases of the four channel runs
	localparam logic [7:0] DUTY_BASE_0 = 8'h03;
	localparam logic [7:0] DUTY_BASE_1 = 8'h0f;
	localparam logic [7:0] DUTY_BASE_2 = 8'h27;
	localparam logic [7:0] DUTY_BASE_3 = 8'h3d;
	localparam logic [7:0] SCALE_BASE_0 = 8'h4b;
	localparam logic [7:0] SCALE_BASE_1 = 8'h51;
	localparam logic [7:0] SCALE_BASE_2 = 8'h5d;
	localparam logic [7:0] SCALE_BASE_3 = 8'h68;
	localparam int RUN_FIRST_1 = 5;
	localparam int RUN_FIRST_2 = 15;
	localparam int RUN_FIRST_3 = 25;

	// ************************************************************
	// fields, masks, codes and reset values
	// ************************************************************
	localparam logic [7:0] TRIGGER_KEY = 8'h00;
	localparam logic [7:0] CTRL_MASK = 8'h77;
	localparam logic [7:0] PHASE_MASK = 8'hbf;
	localparam logic [7:0] DETECT_MASK = 8'h03;
	localparam logic [7:0] THERM_WR_MASK = 8'hc3;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_RES_LSB = 1;
	localparam int PHASE_ON_BIT = 7;
	localparam int THERM_FLAG_BIT = 4;
	localparam int THERM_ROLL_LSB = 6;
	localparam int SPREAD_ON_BIT = 4;
	localparam int SPREAD_RANGE_LSB = 2;
	localparam int FORCED_LSB = 5;
	localparam logic [1:0] DET_SHORT = 2'h2;
	localparam logic [1:0] DET_OPEN = 2'h3;
	localparam logic [15:0] DUTY_ONE_STEP = 16'h0001;

	// ************************************************************
	// spread modulation periods
	// ************************************************************
	localparam int SPREAD_T0_US = 1980;
	localparam int SPREAD_T1_US = 1200;
	localparam int SPREAD_T2_US = 820;
	localparam int SPREAD_T3_US = 660;
	localparam int SPREAD_T0_CYC = SPREAD_T0_US * CLK_MHZ;
	localparam int SPREAD_T1_CYC = SPREAD_T1_US * CLK_MHZ;
	localparam int SPREAD_T2_CYC = SPREAD_T2_US * CLK_MHZ;
	localparam int SPREAD_T3_CYC = SPREAD_T3_US * CLK_MHZ;

	// ************************************************************
	// whole state of the block
	// ************************************************************
	typedef struct packed {
		logic [7:0] ctrl;
		logic [NCH-1:0][15:0] duty_stage;
		logic [NCH-1:0][15:0] duty_live;
		logic [NCH-1:0][7:0] scale;
		logic [7:0] global;
		logic [7:0] phase;
		logic [1:0] detect;
		logic [NCH-1:0] fault;
		logic [7:0] thermal;
		logic [7:0] spread;
		logic [7:0] rd_data;
		logic [15:0] pwm_cnt;
		logic [NCH-1:0] pwm_out;
		logic [NCH-1:0][15:0] peak;
		logic [17:0] spread_cnt;
		logic spread_wrap;
	} lcp_state_s;

	localparam lcp_state_s STATE_RESET = '0;

	// low duty byte offset of a channel, 0-based
	function automatic logic [7:0] duty_lo_addr(input int ch);
		logic [7:0] a;
		if (ch < RUN_FIRST_1)
			a = DUTY_BASE_0 + 8'(2 * ch);
		else if (ch < RUN_FIRST_2)
			a = DUTY_BASE_1 + 8'(2 * (ch - RUN_FIRST_1));
		else if (ch < RUN_FIRST_3)
			a = DUTY_BASE_2 + 8'(2 * (ch - RUN_FIRST_2));
		else
			a = DUTY_BASE_3 + 8'(2 * (ch - RUN_FIRST_3));
		return a;
	endfunction

	// current scale offset of a channel, 0-based
	function automatic logic [7:0] scale_addr(input int ch);
		logic [7:0] a;
		if (ch < RUN_FIRST_1)
			a = SCALE_BASE_0 + 8'(ch);
		else if (ch < RUN_FIRST_2)
			a = SCALE_BASE_1 + 8'(ch - RUN_FIRST_1);
		else if (ch < RUN_FIRST_3)
			a = SCALE_BASE_2 + 8'(ch - RUN_FIRST_2);
		else
			a = SCALE_BASE_3 + 8'(ch - RUN_FIRST_3);
		return a;
	endfunction

endpackage

// File: logic/lcp_core.sv
// register file, duty update, pwm outputs and status capture of a 30 channel led driver
// assumes a byte register port from a serial slave, fault and thermal comparators outside
// What this block does
// - update write of 0x00 with pin high and run bit set loads staged duties
// - channel current scale acts as soon as written, no update needed
// - peak current code is global times channel scale, 256 steps each
// - global current scale, reset zero, scales all channel peak currents
// - phase register bit 7 enables six-phase delay, resets to zero
// - phase select bits 5:0 choose 0 or 180 degrees, reset zero
// - detect mode 10 captures shorts, 11 opens, 00 and 01 disable
// - fault status holds only the selected fault type, never both
// - one fault bit per channel over five registers, unused bits zero
// - threshold field bits 1:0 pick 140, 120, 100 or 90 degrees
// - roll-off field bits 7:6 limit current to 100, 75, 55, 30 percent
// - thermal bit 4 reads one while die is above threshold
// - without forcing outputs follow duty; one step gives no pulse
// - forced-on bits 7:5 drive channel groups of ten fully on while running
// - spread bit 4 enables clock spreading, resets to zero
// - cycle field bits 1:0 set period 1980, 1200, 820, 660 us
// - range field bits 3:2 set deviation 5, 15, 24, 34 percent
// - reset register write of 0x00 returns every register to default
// - duty is the binary value of high and low bytes
// - two duty bytes per channel, low first; 8-bit mode ignores high byte
// - control holds run bit and two-bit resolution 8, 10, 12, 16
`timescale 1ns/1ps

module lcp_core
	import lcp_pkg::*;
#(
	parameter int SPREAD_CYC_0 = SPREAD_T0_CYC,
	parameter int SPREAD_CYC_1 = SPREAD_T1_CYC,
	parameter int SPREAD_CYC_2 = SPREAD_T2_CYC,
	parameter int SPREAD_CYC_3 = SPREAD_T3_CYC
)
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data,
	// pins and analogue comparators
	input wire logic shutdown_pin_n,
	input wire logic [NCH-1:0] short_detect_in,
	input wire logic [NCH-1:0] open_detect_in,
	input wire logic die_over_threshold,
	// channel outputs
	output logic [NCH-1:0] pwm_out,
	output logic [NCH-1:0][7:0] channel_scale,
	output logic [7:0] global_scale,
	output logic [NCH-1:0][15:0] peak_current,
	// analogue and clock settings
	output logic phase_delay_on,
	output logic [5:0] phase_select,
	output logic [1:0] fault_detect_mode,
	output logic [1:0] thermal_threshold,
	output logic [1:0] rolloff_percent,
	output logic spread_enable,
	output logic [1:0] spread_cycle_time,
	output logic [1:0] spread_range,
	output logic spread_wrap,
	output logic [1:0] duty_resolution
);

	// ************************************************************
	// state and request decode
	// ************************************************************
	lcp_state_s st_q;
	lcp_state_s st_d;

	logic wr_ok;
	logic soft_reset;
	logic update_hit;
	logic run_active;
	logic [15:0] cnt_max;
	logic [NCH-1:0] duty_lo_hit;
	logic [NCH-1:0] duty_hi_hit;
	logic [NCH-1:0] scale_hit;
	logic [NCH-1:0][7:0] rd_part;
	logic [NCH-1:0] pwm_next;
	logic [NCH-1:0][15:0] peak_next;
	logic [7:0] rd_mux;
	logic [17:0] spread_limit;

	// trigger writes act only for the key value
	assign wr_ok = wr_en;
	assign soft_reset = wr_ok && wr_addr == ADDR_RESET && wr_data == TRIGGER_KEY;
	assign update_hit = wr_ok && wr_addr == ADDR_UPDATE && wr_data == TRIGGER_KEY;
	assign run_active = shutdown_pin_n && st_q.ctrl[CTRL_RUN_BIT];

	// pwm period end for the selected resolution
	always_comb
	begin
		case (st_q.ctrl[CTRL_RES_LSB +: 2])
			2'h0: cnt_max = 16'h00ff;
			2'h1: cnt_max = 16'h03ff;
			2'h2: cnt_max = 16'h0fff;
			default: cnt_max = 16'hffff;
		endcase
	end

	// spread modulation period in clock cycles
	always_comb
	begin
		case (st_q.spread[1:0])
			2'h0: spread_limit = 18'(SPREAD_CYC_0);
			2'h1: spread_limit = 18'(SPREAD_CYC_1);
			2'h2: spread_limit = 18'(SPREAD_CYC_2);
			default: spread_limit = 18'(SPREAD_CYC_3);
		endcase
	end

	// ************************************************************
	// per-channel decode, read slices, pwm compare, peak code
	// ************************************************************
	for (genvar c = 0; c < NCH; c++)
	begin : g_ch
		localparam int GRP = c / GROUP_SIZE;
		logic [15:0] duty_eff;

		assign duty_lo_hit[c] = wr_addr == duty_lo_addr(c);
		assign duty_hi_hit[c] = wr_addr == duty_lo_addr(c) + 8'h01;
		assign scale_hit[c] = wr_addr == scale_addr(c);

		// read slice of this channel, zero when not addressed
		assign rd_part[c] = (rd_addr == duty_lo_addr(c)) ? st_q.duty_stage[c][7:0] :
			(rd_addr == duty_lo_addr(c) + 8'h01) ? st_q.duty_stage[c][15:8] :
			(rd_addr == scale_addr(c)) ? st_q.scale[c] : 8'h00;

		// duty bits above the resolution are ignored
		always_comb
		begin
			case (st_q.ctrl[CTRL_RES_LSB +: 2])
				2'h0: duty_eff = {8'h00, st_q.duty_live[c][7:0]};
				2'h1: duty_eff = {6'h00, st_q.duty_live[c][9:0]};
				2'h2: duty_eff = {4'h0, st_q.duty_live[c][11:0]};
				default: duty_eff = st_q.duty_live[c];
			endcase
		end

		// while running a forced group is fully on, otherwise compare; a single step stays dark
		assign pwm_next[c] = run_active &&
			(st_q.spread[FORCED_LSB + GRP] ||
			(duty_eff > st_q.pwm_cnt && duty_eff != DUTY_ONE_STEP));

		// peak current code in 1/65536 of full scale
		assign peak_next[c] = st_q.global * st_q.scale[c];
	end

	// ************************************************************
	// register read multiplexer
	// ************************************************************
	always_comb
	begin
		rd_mux = 8'h00;
		for (int c = 0; c < NCH; c++)
			rd_mux = rd_mux | rd_part[c];
		case (rd_addr)
			ADDR_CTRL: rd_mux = st_q.ctrl;
			ADDR_GLOBAL: rd_mux = st_q.global;
			ADDR_PHASE: rd_mux = st_q.phase;
			ADDR_DETECT: rd_mux = {6'h00, st_q.detect};
			// fault bits packed around the unused positions
			ADDR_FAULT0: rd_mux = {st_q.fault[5], 1'b0, st_q.fault[4:0], 1'b0};
			ADDR_FAULT1: rd_mux = st_q.fault[13:6];
			ADDR_FAULT2: rd_mux = {st_q.fault[19:15], 2'h0, st_q.fault[14]};
			ADDR_FAULT3: rd_mux = {st_q.fault[26:25], 1'b0, st_q.fault[24:20]};
			ADDR_FAULT4: rd_mux = {5'h00, st_q.fault[29:27]};
			ADDR_THERMAL: rd_mux = st_q.thermal;
			ADDR_SPREAD: rd_mux = st_q.spread;
			ADDR_UPDATE: rd_mux = 8'h00;
			ADDR_RESET: rd_mux = 8'h00;
			default: rd_mux = rd_mux;
		endcase
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb
	begin
		st_d = st_q;

		// register writes
		if (wr_ok)
		begin
			case (wr_addr)
				ADDR_CTRL: st_d.ctrl = wr_data & CTRL_MASK;
				ADDR_GLOBAL: st_d.global = wr_data;
				ADDR_PHASE: st_d.phase = wr_data & PHASE_MASK;
				ADDR_DETECT: st_d.detect = wr_data[1:0] & DETECT_MASK[1:0];
				ADDR_THERMAL: st_d.thermal = (wr_data & THERM_WR_MASK) |
					(st_q.thermal & ~THERM_WR_MASK);
				ADDR_SPREAD: st_d.spread = wr_data;
				default: st_d.ctrl = st_d.ctrl;
			endcase
			for (int c = 0; c < NCH; c++)
			begin
				if (duty_lo_hit[c])
					st_d.duty_stage[c][7:0] = wr_data;
				if (duty_hi_hit[c])
					st_d.duty_stage[c][15:8] = wr_data;
				if (scale_hit[c])
					st_d.scale[c] = wr_data;
			end
		end

		// staged duties go live only on the keyed update while running
		// a refused strobe leaves no sign; the staged values simply wait
		if (update_hit && shutdown_pin_n && st_q.ctrl[CTRL_RUN_BIT])
			st_d.duty_live = st_q.duty_stage;

		// live capture of the selected fault type only
		// modes 00 and 01 keep the last image so the host can still read it
		if (st_q.detect == DET_SHORT)
			st_d.fault = short_detect_in;
		else if (st_q.detect == DET_OPEN)
			st_d.fault = open_detect_in;

		// die temperature flag follows the comparator
		// rewritten every cycle, so a host write to bit 4 never sticks
		st_d.thermal[THERM_FLAG_BIT] = die_over_threshold;

		// pwm period counter, parked while not running
		// leaving shutdown restarts the period at zero, so the first on-time is whole
		if (!run_active || st_q.pwm_cnt >= cnt_max)
			st_d.pwm_cnt = 16'h0000;
		else
			st_d.pwm_cnt = 16'(st_q.pwm_cnt + 16'h0001);
		st_d.pwm_out = pwm_next;
		st_d.peak = peak_next;

		// spread modulation period timer with a wrap pulse
		// the pulse marks where the clock modulator restarts its sweep
		st_d.spread_wrap = 1'b0;
		if (!st_q.spread[SPREAD_ON_BIT])
			st_d.spread_cnt = 18'h00000;
		else if (st_q.spread_cnt >= spread_limit - 18'h00001)
		begin
			st_d.spread_cnt = 18'h00000;
			st_d.spread_wrap = 1'b1;
		end
		else
			st_d.spread_cnt = 18'(st_q.spread_cnt + 18'h00001);

		// read answer, held until the next read
		if (rd_en)
			st_d.rd_data = rd_mux;

		// keyed soft reset returns everything to defaults
		// it also clears the read answer, so a read in that cycle returns zero
		if (soft_reset)
			st_d = STATE_RESET;
	end

	// state register
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			st_q <= STATE_RESET;
		else
			st_q <= st_d;
	end

	// ************************************************************
	// outputs, all straight from the state register
	// ************************************************************
	assign rd_data = st_q.rd_data;
	assign pwm_out = st_q.pwm_out;
	assign channel_scale = st_q.scale;
	assign global_scale = st_q.global;
	assign peak_current = st_q.peak;
	assign phase_delay_on = st_q.phase[PHASE_ON_BIT];
	assign phase_select = st_q.phase[5:0];
	assign fault_detect_mode = st_q.detect;
	assign thermal_threshold = st_q.thermal[1:0];
	assign rolloff_percent = st_q.thermal[THERM_ROLL_LSB +: 2];
	assign spread_enable = st_q.spread[SPREAD_ON_BIT];
	assign spread_cycle_time = st_q.spread[1:0];
	assign spread_range = st_q.spread[SPREAD_RANGE_LSB +: 2];
	assign spread_wrap = st_q.spread_wrap;
	assign duty_resolution = st_q.ctrl[CTRL_RES_LSB +: 2];

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	sequence upd_wr_s;
		update_hit && shutdown_pin_n && st_q.ctrl[CTRL_RUN_BIT];
	endsequence

	sequence soft_rst_s;
		wr_en && wr_addr == ADDR_RESET && wr_data == TRIGGER_KEY;
	endsequence

	// keyed update while running copies every staged duty
	update_copy_a: assert property (upd_wr_s |=> st_q.duty_live == $past(st_q.duty_stage))
		else $error("staged duties not applied on update");

	// live duties move only on a keyed update
	update_gate_a: assert property (!soft_reset && !(update_hit && run_active) |=> $stable(st_q.duty_live))
		else $error("live duties changed without a keyed update");

	// channel scale takes the written byte at once
	scale_now_a: assert property (wr_en && wr_addr == scale_addr(0) && !soft_reset
		|=> channel_scale[0] == $past(wr_data))
		else $error("channel scale not applied at once");

	// peak code of the last channel is the full product of both scales, outside soft reset
	peak_calc_a: assert property ($past(nrst) && !$past(soft_reset) |-> peak_current[NCH-1] ==
		16'($past(st_q.global)) * 16'($past(st_q.scale[NCH-1])))
		else $error("peak current code wrong");

	// keyed soft reset clears settings and darkens outputs
	reset_clear_a: assert property (soft_rst_s |=> global_scale == 8'h00 && phase_delay_on == 1'b0
		&& phase_select == 6'h00 && !spread_enable ##1 pwm_out == '0)
		else $error("soft reset left a register set");

	// short mode copies the short comparators
	fault_short_a: assert property (st_q.detect == DET_SHORT && !soft_reset
		|=> st_q.fault == $past(short_detect_in))
		else $error("short capture wrong");

	// disabled detection holds the status image
	fault_hold_a: assert property (!st_q.detect[1] && !soft_reset |=> $stable(st_q.fault))
		else $error("fault bits moved while detection off");

	// thermal flag follows the comparator one cycle late
	temp_flag_a: assert property (!soft_reset |=> st_q.thermal[THERM_FLAG_BIT] == $past(die_over_threshold))
		else $error("thermal flag does not follow comparator");

	// forced first group stays on while running
	forced_on_a: assert property (run_active && st_q.spread[FORCED_LSB] && !soft_reset |=> pwm_out[0])
		else $error("forced group not fully on");

	// a single duty step never lights the channel
	one_step_a: assert property (!st_q.spread[FORCED_LSB] && st_q.duty_live[0] == DUTY_ONE_STEP && !soft_reset
		|=> !pwm_out[0])
		else $error("single duty step produced a pulse");

	// trigger registers read back as zero
	trig_read_a: assert property (rd_en && (rd_addr == ADDR_UPDATE || rd_addr == ADDR_RESET) && !soft_reset
		|=> rd_data == 8'h00)
		else $error("trigger register read not zero");

	// a wrong reset key leaves the registers alone
	reset_key_a: assert property (wr_en && wr_addr == ADDR_RESET && wr_data != TRIGGER_KEY
		|=> $stable(global_scale))
		else $error("soft reset taken for a wrong key");

	// no output lights while stopped
	dark_stop_a: assert property (!run_active |=> pwm_out == '0)
		else $error("output on while stopped");

	// no wrap pulse while spreading is off
	spread_idle_a: assert property (!st_q.spread[SPREAD_ON_BIT] |=> !spread_wrap)
		else $error("spread wrap while disabled");

	// open mode copies the open comparators
	fault_open_a: assert property (st_q.detect == DET_OPEN && !soft_reset
		|=> st_q.fault == $past(open_detect_in))
		else $error("open capture wrong");

	// global scale reads back as stored
	global_read_a: assert property (rd_en && rd_addr == ADDR_GLOBAL && !soft_reset
		|=> rd_data == $past(st_q.global))
		else $error("global scale read wrong");

endmodule

// File: verif/lcp_host_model.sv
// host model driving the byte register port of the led channel block
// assumes requests taken on the rising edge of clk, read answer one cycle later
`timescale 1ns/1ps

module lcp_host_model
(
	// clock
	input wire logic clk,
	// register port
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic rd_en,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data
);
	// ************************************************************
	// bus cycles
	// ************************************************************
	// idle port at time zero
	initial
	begin
		wr_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		rd_en = 1'b0;
		rd_addr = 8'h00;
	end

	// one byte write; released lines show the inverse so stale values never pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(posedge clk);
		#1;
		wr_en = 1'b0;
		wr_addr = ~a;
		wr_data = ~d;
	endtask

	// one byte read, answer taken after the taking edge has landed
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		rd_en = 1'b1;
		rd_addr = a;
		@(posedge clk);
		#1;
		rd_en = 1'b0;
		rd_addr = ~a;
		d = rd_data;
	endtask

	// thermal read always preceded by a fresh write of its setting fields
	task automatic rd_therm(input logic [7:0] v, output logic [7:0] d);
		wr(8'h77, v);
		rd(8'h77, d);
	endtask
endmodule

// File: verif/lcp_core_bench.sv
// self-checking bench of the led channel block, register sequences with expected values
// assumes the host model file and the package are compiled first
`timescale 1ns/1ps

`define CHK(nm, e, g) \
	begin \
		samples_checked++; \
		if ((g) !== (e)) \
		begin \
			n_fail++; \
			$display("wrong value %s expected %h seen %h", nm, e, g); \
		end \
	end

module lcp_core_bench
	import lcp_pkg::*;
;
	// ************************************************************
	// signals
	// ************************************************************
	logic clk, nrst, shutdown_pin_n, die_over_threshold;
	logic [NCH-1:0] short_detect_in, open_detect_in, pwm_out;
	logic wr_en, rd_en, phase_delay_on, spread_enable, spread_wrap;
	logic [7:0] wr_addr, wr_data, rd_addr, rd_data, global_scale, d;
	logic [NCH-1:0][7:0] channel_scale;
	logic [NCH-1:0][15:0] peak_current;
	logic [5:0] phase_select;
	logic [1:0] fault_detect_mode, thermal_threshold, rolloff_percent, spread_cycle_time, spread_range;
	logic [1:0] duty_resolution;
	int n_fail = 0;
	int samples_checked = 0;
	int n;
	logic [7:0] rst_addr [8] = '{8'h00, 8'h4b, 8'h6e, 8'h70, 8'h71, 8'h72, 8'h76, 8'h78};
	logic [7:0] short_img [5] = '{8'hbe, 8'hff, 8'hf9, 8'hdf, 8'h07};
	int per [4] = '{20, 18, 16, 14};

	// ************************************************************
	// design, host and clock
	// ************************************************************
	lcp_core #(.SPREAD_CYC_0(20), .SPREAD_CYC_1(18), .SPREAD_CYC_2(16), .SPREAD_CYC_3(14)) dut (
		.clk(clk), .nrst(nrst), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .shutdown_pin_n(shutdown_pin_n),
		.short_detect_in(short_detect_in), .open_detect_in(open_detect_in),
		.die_over_threshold(die_over_threshold), .pwm_out(pwm_out), .channel_scale(channel_scale),
		.global_scale(global_scale), .peak_current(peak_current), .phase_delay_on(phase_delay_on),
		.phase_select(phase_select), .fault_detect_mode(fault_detect_mode),
		.thermal_threshold(thermal_threshold), .rolloff_percent(rolloff_percent),
		.spread_enable(spread_enable), .spread_cycle_time(spread_cycle_time),
		.spread_range(spread_range), .spread_wrap(spread_wrap), .duty_resolution(duty_resolution));

	lcp_host_model host (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data));

	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ************************************************************
	// helpers
	// ************************************************************
	// verdict and end of run
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// on cycles of one channel, or spread wraps when ch is negative
	task automatic count_on(input int ch, input int cycles, output int k);
		k = 0;
		repeat (4) @(posedge clk);
		repeat (cycles)
		begin
			@(posedge clk);
			#1;
			if ((ch < 0) ? (spread_wrap === 1'b1) : (pwm_out[ch] === 1'b1))
				k++;
		end
	endtask

	// hang guard
	initial
	begin
		repeat (60000) @(posedge clk);
		n_fail++;
		tally_and_finish();
	end

	// ************************************************************
	// scenarios
	// ************************************************************
	initial
	begin
		nrst = 1'b0;
		shutdown_pin_n = 1'b1;
		die_over_threshold = 1'b0;
		short_detect_in = '0;
		open_detect_in = '0;
		repeat (2) @(posedge clk);
		#1;
		nrst = 1'b1;
		// defaults
		for (int i = 0; i < 8; i++)
		begin
			host.rd(rst_addr[i], d);
			`CHK("reset value", 8'h00, d);
		end
		// scales act at once
		host.wr(ADDR_GLOBAL, 8'h01);
		host.wr(8'h4b, 8'hff);
		host.wr(8'h6c, 8'h80);
		repeat (2) @(posedge clk);
		#1;
		`CHK("scale ch1", 8'hff, channel_scale[0]);
		`CHK("peak ch1", 16'h00ff, peak_current[0]);
		`CHK("peak ch30", 16'h0080, peak_current[29]);
		// phase fields
		host.wr(ADDR_PHASE, 8'hff);
		host.rd(ADDR_PHASE, d);
		`CHK("phase read", 8'hbf, d);
		`CHK("phase on", 1'b1, phase_delay_on);
		`CHK("phase select", 6'h3f, phase_select);
		host.wr(ADDR_PHASE, 8'h15);
		`CHK("phase off", 1'b0, phase_delay_on);
		`CHK("phase select b", 6'h15, phase_select);
		// staged duty and update strobe
		host.wr(ADDR_CTRL, 8'h01);
		host.wr(8'h03, 8'h04);
		host.wr(8'h04, 8'h01);
		count_on(0, 256, n);
		`CHK("before update", 0, n);
		host.wr(ADDR_UPDATE, 8'h01);
		count_on(0, 256, n);
		`CHK("nonzero update", 0, n);
		shutdown_pin_n = 1'b0;
		host.wr(ADDR_UPDATE, 8'h00);
		shutdown_pin_n = 1'b1;
		count_on(0, 256, n);
		`CHK("update in shutdown", 0, n);
		host.wr(ADDR_UPDATE, 8'h00);
		count_on(0, 256, n);
		`CHK("duty four", 4, n);
		host.rd(ADDR_UPDATE, d);
		`CHK("update read", 8'h00, d);
		host.wr(8'h03, 8'h01);
		host.wr(8'h04, 8'h00);
		host.wr(ADDR_UPDATE, 8'h00);
		count_on(0, 256, n);
		`CHK("duty one", 0, n);
		// ten bit resolution uses both duty bytes
		host.wr(8'h04, 8'h01);
		host.wr(ADDR_CTRL, 8'h03);
		host.wr(ADDR_UPDATE, 8'h00);
		count_on(0, 1024, n);
		`CHK("duty ten bit", 257, n);
		host.wr(ADDR_CTRL, 8'h01);
		// forced groups
		for (int g = 0; g < 3; g++)
		begin
			host.wr(ADDR_SPREAD, 8'h20 << g);
			count_on(10 * g, 256, n);
			`CHK("forced group", 256, n);
			count_on((10 * g + 10) % 30, 256, n);
			`CHK("unforced group", 0, n);
		end
		host.wr(ADDR_SPREAD, 8'h20);
		host.wr(ADDR_CTRL, 8'h00);
		count_on(0, 256, n);
		`CHK("soft shutdown", 0, n);
		for (int r = 0; r < 4; r++)
		begin
			host.wr(ADDR_CTRL, 8'(r * 2));
			`CHK("resolution", 2'(r), duty_resolution);
		end
		// fault capture
		short_detect_in = '1;
		host.wr(ADDR_DETECT, 8'h02);
		`CHK("detect mode", 2'h2, fault_detect_mode);
		for (int i = 0; i < 5; i++)
		begin
			host.rd(ADDR_FAULT0 + 8'(i), d);
			`CHK("short status", short_img[i], d);
		end
		host.wr(ADDR_DETECT, 8'h03);
		for (int i = 0; i < 5; i++)
		begin
			host.rd(ADDR_FAULT0 + 8'(i), d);
			`CHK("open status", 8'h00, d);
		end
		host.wr(ADDR_DETECT, 8'h01);
		open_detect_in = '1;
		host.rd(ADDR_FAULT0, d);
		`CHK("detect off", 8'h00, d);
		host.wr(ADDR_DETECT, 8'h03);
		host.wr(ADDR_FAULT0, 8'h00);
		host.rd(ADDR_FAULT0, d);
		`CHK("open capture", 8'hbe, d);
		// thermal fields and flag
		for (int i = 0; i < 4; i++)
		begin
			die_over_threshold = i[0];
			host.rd_therm({2'(i), 4'h0, 2'(i)}, d);
			`CHK("thermal read", {2'(i), 1'b0, i[0], 2'h0, 2'(i)}, d);
			`CHK("threshold", 2'(i), thermal_threshold);
			`CHK("rolloff", 2'(i), rolloff_percent);
		end
		// spread fields and period
		for (int i = 0; i < 4; i++)
		begin
			host.wr(ADDR_SPREAD, 8'h10 | 8'(i * 5));
			`CHK("spread range", 2'(i), spread_range);
			`CHK("spread cycle", 2'(i), spread_cycle_time);
			`CHK("spread on", 1'b1, spread_enable);
			count_on(-1, per[i] * 3, n);
			`CHK("spread period", 3, n);
		end
		host.wr(ADDR_SPREAD, 8'h00);
		count_on(-1, 60, n);
		`CHK("spread off", 0, n);
		// soft reset
		host.wr(ADDR_GLOBAL, 8'h55);
		host.wr(ADDR_RESET, 8'h01);
		host.rd(ADDR_GLOBAL, d);
		`CHK("reset ignored", 8'h55, d);
		host.wr(ADDR_RESET, 8'h00);
		host.rd(ADDR_GLOBAL, d);
		`CHK("reset global", 8'h00, d);
		host.rd(ADDR_PHASE, d);
		`CHK("reset phase", 8'h00, d);
		host.rd(8'h7e, d);
		`CHK("unmapped read", 8'h00, d);
		// hardware reset in mid-run
		host.wr(ADDR_GLOBAL, 8'h33);
		nrst = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		nrst = 1'b1;
		`CHK("hard reset global", 8'h00, global_scale);
		host.rd(ADDR_GLOBAL, d);
		`CHK("hard reset read", 8'h00, d);
		tally_and_finish();
	end
endmodule
